// File: fpc_pkg.sv
// Shared constants and types of the coprocessor register and context block
package fpc_pkg;

    // Register file geometry
    localparam int unsigned REG_COUNT   = 32;
    localparam int unsigned WORD_W      = 32;
    localparam int unsigned IDX_W       = 5;

    // Context word fields
    localparam int unsigned SEL_HI      = 31;
    localparam int unsigned SEL_LO      = 28;
    localparam int unsigned RC_HI       = 27;
    localparam int unsigned RC_LO       = 24;
    localparam int unsigned MASK_HI     = 23;
    localparam int unsigned MASK_LO     = 16;
    localparam int unsigned CMP_HI      = 15;
    localparam int unsigned CMP_LO      = 8;
    localparam int unsigned STK_HI      = 7;
    localparam int unsigned STK_LO      = 0;

    // Write-select codes
    localparam logic [3:0] SEL_KEEP_RC  = 4'hC;
    localparam logic [3:0] SEL_ALL      = 4'h0;

    // Rounding control layout and reset value (fast mode set)
    localparam int unsigned RC_SEL_HI   = 3;
    localparam int unsigned RC_SEL_LO   = 2;
    localparam int unsigned RC_INT_BIT  = 1;
    localparam int unsigned RC_FAST_BIT = 0;
    localparam logic [3:0] RC_RESET     = 4'h1;

    // Rounding select encodings
    localparam logic [1:0] RND_NEAREST  = 2'h0;
    localparam logic [1:0] RND_ZERO     = 2'h1;
    localparam logic [1:0] RND_POS      = 2'h2;
    localparam logic [1:0] RND_NEG      = 2'h3;

    // Sticky byte and trap mask byte bit positions
    localparam int unsigned B_CHAIN     = 7;
    localparam int unsigned B_BADOP     = 6;
    localparam int unsigned B_INEXACT   = 5;
    localparam int unsigned B_UNDER     = 4;
    localparam int unsigned B_OVER      = 3;
    localparam int unsigned B_DIVNIL    = 2;
    localparam int unsigned B_TRAP      = 1;
    localparam int unsigned B_INVALID   = 0;
    // Chain flag and trap-pending bit are never taken from a fault source
    localparam logic [7:0] EXC_BITS     = 8'h7D;
    localparam logic [7:0] MASK_RESET   = 8'hFD;
    localparam logic [7:0] STK_RESET    = 8'h00;

    // Compare field encodings
    localparam logic [7:0] CMP_EQUAL    = 8'h40;
    localparam logic [7:0] CMP_LESS     = 8'h01;
    localparam logic [7:0] CMP_GREATER  = 8'h00;
    localparam logic [7:0] CMP_UNORD    = 8'h45;
    localparam logic [7:0] CMP_RESET    = 8'h00;

    // Instruction opcodes
    localparam logic [3:0] OP_MOVE      = 4'h0;
    localparam logic [3:0] OP_LDCTX     = 4'h1;
    localparam logic [3:0] OP_STCTX     = 4'h2;
    localparam logic [3:0] OP_STORE     = 4'h3;
    localparam logic [3:0] OP_ARITH     = 4'h4;
    localparam logic [3:0] OP_CMP       = 4'h5;
    localparam logic [3:0] OP_TEST      = 4'h6;

    // First-source kinds
    localparam logic [1:0] SRC_REG      = 2'h0;
    localparam logic [1:0] SRC_HOST     = 2'h1;
    localparam logic [1:0] SRC_IMM      = 2'h2;

    typedef enum logic [1:0] {
        FPC_CMP_EQ,
        FPC_CMP_LT,
        FPC_CMP_GT,
        FPC_CMP_UN
    } fpc_cmp_t;

    typedef struct packed {
        logic [3:0]       op;
        logic             dbl;
        logic [1:0]       s1_kind;
        logic [IDX_W-1:0] s2;
        logic [IDX_W-1:0] s1;
    } fpc_instr_t;

    typedef struct packed {
        logic [WORD_W-1:0] hi;
        logic [WORD_W-1:0] lo;
    } fpc_dword_t;

endpackage

// File: fpc_core.sv
// Coprocessor register file, context word, sticky faults and trap request
`timescale 1ns/10ps
`default_nettype none

module fpc_core #(
    parameter int unsigned NREGS = fpc_pkg::REG_COUNT
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_b,
    // Instruction from host
    input  wire logic               ins_valid,
    input  wire fpc_pkg::fpc_instr_t ins,
    input  wire logic [31:0]        host_data,
    output logic                    ins_ready,
    // Read answer to host
    output logic                    rd_valid,
    output logic [31:0]             rd_data,
    // Arithmetic unit request
    output logic                    alu_req,
    output logic [3:0]              alu_op,
    output logic                    alu_dbl,
    output fpc_pkg::fpc_dword_t     alu_a,
    output fpc_pkg::fpc_dword_t     alu_b,
    output logic [1:0]              alu_round_sel,
    output logic                    alu_int_round_zero,
    // Arithmetic unit answer
    input  wire logic               alu_done,
    input  wire fpc_pkg::fpc_dword_t alu_res,
    input  wire logic [7:0]         alu_exc,
    input  wire fpc_pkg::fpc_cmp_t  alu_cmp,
    // Trap request to host
    output logic                    trap_request
);
    import fpc_pkg::*;

    initial begin
        if (NREGS != REG_COUNT) begin
            $error("fpc_core: register count must be 32");
        end
        if (WORD_W != 32) begin
            $error("fpc_core: context word must be 32 bits");
        end
    end

    // Only arithmetic, compare and test hold the host off;
    // every other operation completes in the cycle it is taken

    typedef enum logic [0:0] {
        FPC_IDLE,
        FPC_WAIT
    } fpc_state_t;

    fpc_state_t        state_r;
    fpc_instr_t        cur_r;
    // No reset on the file: contents are undefined until software loads them,
    // which keeps the array free of a reset tree
    logic [WORD_W-1:0] regs [REG_COUNT];
    logic [3:0]        rounding_control_r;
    logic [7:0]        trap_mask_byte_r;
    logic [7:0]        compare_result_field_r;
    logic [7:0]        sticky_fault_byte_r;

    logic              take;
    logic              known_op;
    logic              local_end;
    logic              end_evt;
    logic [7:0]        end_exc;
    logic [IDX_W-1:0]  s2_even;
    logic [IDX_W-1:0]  s1_even;
    fpc_dword_t        src1_val;
    fpc_dword_t        src2_val;
    logic [7:0]        cmp_code;
    logic [31:0]        ctx_read;
    logic [3:0]        wsel;

    assign take    = ins_valid && ins_ready;
    assign wsel    = host_data[SEL_HI:SEL_LO];
    assign s2_even = {ins.s2[IDX_W-1:1], 1'b0};
    assign s1_even = {ins.s1[IDX_W-1:1], 1'b0};

    // Opcodes outside this list are still taken, so the host never stalls
    // on a foreign instruction; they only raise the bad-opcode fault
    always_comb begin
        case (ins.op)
            OP_MOVE, OP_LDCTX, OP_STCTX, OP_STORE, OP_ARITH, OP_CMP, OP_TEST: known_op = 1'b1;
            default: known_op = 1'b0;
        endcase
    end

    // Operand fetch; a double is the even register high, the odd one low.
    // An odd index in a double is rounded down, so a stray low bit from
    // software cannot split a pair across two doubles.
    always_comb begin
        src2_val.hi = ins.dbl ? regs[s2_even] : regs[ins.s2];
        src2_val.lo = ins.dbl ? regs[s2_even + 5'h01] : 32'h00000000;
        case (ins.s1_kind)
            SRC_HOST, SRC_IMM: begin
                // Host double: host word high, single register 1 low
                src1_val.hi = host_data;
                src1_val.lo = ins.dbl ? regs[5'h01] : 32'h00000000;
            end
            default: begin
                src1_val.hi = ins.dbl ? regs[s1_even] : regs[ins.s1];
                src1_val.lo = ins.dbl ? regs[s1_even + 5'h01] : 32'h00000000;
            end
        endcase
    end

    // Sequencer: local ops end in the taking cycle, arithmetic waits for the unit.
    // Only one request is ever outstanding, so the answer needs no tag.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= FPC_IDLE;
        end else begin
            case (state_r)
                FPC_IDLE: begin
                    if (take && known_op &&
                        (ins.op == OP_ARITH || ins.op == OP_CMP || ins.op == OP_TEST)) begin
                        state_r <= FPC_WAIT;
                    end
                end
                FPC_WAIT: begin
                    if (alu_done) begin
                        state_r <= FPC_IDLE;
                    end
                end
                default: state_r <= FPC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ins_ready <= 1'b1;
        end else if (take && known_op &&
                     (ins.op == OP_ARITH || ins.op == OP_CMP || ins.op == OP_TEST)) begin
            ins_ready <= 1'b0;
        end else if (state_r == FPC_WAIT && alu_done) begin
            ins_ready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_r <= '0;
        end else if (take) begin
            cur_r <= ins;
        end
    end

    // Arithmetic unit launch, one-cycle request.
    // Operands are captured at the take, so later moves cannot disturb them.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            alu_req <= 1'b0;
            alu_op  <= 4'h0;
            alu_dbl <= 1'b0;
            alu_a   <= '0;
            alu_b   <= '0;
        end else begin
            alu_req <= take && (ins.op == OP_ARITH || ins.op == OP_CMP || ins.op == OP_TEST);
            if (take) begin
                alu_op  <= ins.op;
                alu_dbl <= ins.dbl;
                alu_a   <= src1_val;
                alu_b   <= src2_val;
            end
        end
    end

    // Register file writes: the destination is always the second source.
    // A move and an arithmetic result never meet in one cycle, since the
    // core takes nothing while it waits for the unit.
    always_ff @(posedge clk) begin
        if (take && ins.op == OP_MOVE) begin
            if (ins.dbl) begin
                regs[s2_even]         <= src1_val.hi;
                regs[s2_even + 5'h01] <= src1_val.lo;
            end else begin
                regs[ins.s2] <= src1_val.hi;
            end
        end else if (state_r == FPC_WAIT && alu_done && cur_r.op == OP_ARITH) begin
            if (cur_r.dbl) begin
                regs[{cur_r.s2[IDX_W-1:1], 1'b0}] <= alu_res.hi;
                regs[{cur_r.s2[IDX_W-1:1], 1'b1}] <= alu_res.lo;
            end else begin
                regs[cur_r.s2] <= alu_res.hi;
            end
        end
    end

    // Context readback; select nibble carries no state and reads zero.
    // The trap-pending bit is the trap output itself, never a stored copy,
    // so a save always shows the request as the host sees it.
    assign ctx_read = {4'h0, rounding_control_r, trap_mask_byte_r,
                       compare_result_field_r, sticky_fault_byte_r[STK_HI:B_TRAP+1],
                       trap_request, sticky_fault_byte_r[B_INVALID]};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_valid <= 1'b0;
            rd_data  <= 32'h00000000;
        end else begin
            rd_valid <= take && (ins.op == OP_STCTX || ins.op == OP_STORE);
            if (take && ins.op == OP_STCTX) begin
                rd_data <= ctx_read;
            end else if (take && ins.op == OP_STORE) begin
                rd_data <= regs[ins.s2];
            end
        end
    end

    // Instruction end: local ops at take, arithmetic at unit answer
    assign local_end = take && !(known_op &&
                       (ins.op == OP_ARITH || ins.op == OP_CMP || ins.op == OP_TEST));
    assign end_evt   = local_end || (state_r == FPC_WAIT && alu_done);

    always_comb begin
        end_exc = 8'h00;
        if (local_end && !known_op) begin
            end_exc[B_BADOP] = 1'b1;
        end else if (state_r == FPC_WAIT && alu_done) begin
            end_exc = alu_exc & EXC_BITS;
        end
        end_exc[B_CHAIN] = 1'b0;
    end

    // Compare outcome encoding; undefined bits of the field read as zero
    always_comb begin
        case (alu_cmp)
            FPC_CMP_EQ: cmp_code = CMP_EQUAL;
            FPC_CMP_LT: cmp_code = CMP_LESS;
            FPC_CMP_GT: cmp_code = CMP_GREATER;
            default:    cmp_code = CMP_UNORD;
        endcase
    end

    // Rounding control: only the all-fields select reloads it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rounding_control_r <= RC_RESET;
        end else if (take && ins.op == OP_LDCTX && wsel == SEL_ALL) begin
            // Fast-mode bit is stored as written; software keeps it at one
            rounding_control_r <= host_data[RC_HI:RC_LO];
        end
    end

    // Rounding settings handed to the arithmetic unit.
    // One cycle behind the context word; no operation can start sooner,
    // since a context load and a launch never share a cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            alu_round_sel      <= RND_NEAREST;
            alu_int_round_zero <= 1'b0;
        end else begin
            alu_round_sel      <= rounding_control_r[RC_SEL_HI:RC_SEL_LO];
            // Toward zero for conversions when set, else the current select
            alu_int_round_zero <= rounding_control_r[RC_INT_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trap_mask_byte_r <= MASK_RESET;
        end else if (take && ins.op == OP_LDCTX &&
                     (wsel == SEL_KEEP_RC || wsel == SEL_ALL)) begin
            trap_mask_byte_r <= host_data[MASK_HI:MASK_LO];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            compare_result_field_r <= CMP_RESET;
        end else if (take && ins.op == OP_LDCTX &&
                     (wsel == SEL_KEEP_RC || wsel == SEL_ALL)) begin
            compare_result_field_r <= host_data[CMP_HI:CMP_LO];
        end else if (state_r == FPC_WAIT && alu_done &&
                     (cur_r.op == OP_CMP || cur_r.op == OP_TEST)) begin
            compare_result_field_r <= cmp_code;
        end
    end

    // Sticky faults; a context load is itself an instruction end, and
    // the load branch takes priority over the end update
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sticky_fault_byte_r <= STK_RESET;
        end else if (take && ins.op == OP_LDCTX &&
                     (wsel == SEL_KEEP_RC || wsel == SEL_ALL)) begin
            // Zeros clear, the chain flag cannot be forced on
            sticky_fault_byte_r <= host_data[STK_HI:STK_LO] & EXC_BITS;
        end else if (end_evt) begin
            sticky_fault_byte_r <= (sticky_fault_byte_r | end_exc) & EXC_BITS;
        end
    end

    // Trap request: rises at instruction end, on the same edge as the sticky update.
    // It is a level, held until software reloads the context word; the
    // host therefore sees one request per burst of faults, not per fault.
    // Masked faults still accumulate in the sticky byte but never trap.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trap_request <= 1'b0;
        end else if (take && ins.op == OP_LDCTX &&
                     (wsel == SEL_KEEP_RC || wsel == SEL_ALL)) begin
            // Software may drop a pending trap by writing its bit low
            trap_request <= host_data[B_TRAP];
        end else if (end_evt && |(end_exc & ~trap_mask_byte_r & EXC_BITS)) begin
            trap_request <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// File: fpc_core_checker.sv
// Port-level assertions for the coprocessor core
`timescale 1ns/10ps
`default_nettype none
module fpc_core_checker #(
    parameter int unsigned NREGS = fpc_pkg::REG_COUNT
) (
    // Clock and reset
    input wire logic                clk,
    input wire logic                rst_b,
    // Host side
    input wire logic                ins_valid,
    input wire fpc_pkg::fpc_instr_t ins,
    input wire logic [31:0]         host_data,
    input wire logic                ins_ready,
    input wire logic                rd_valid,
    input wire logic                trap_request,
    // Arithmetic side
    input wire logic                alu_req,
    input wire logic [3:0]          alu_op,
    input wire fpc_pkg::fpc_dword_t alu_a,
    input wire logic [1:0]          alu_round_sel,
    input wire logic                alu_int_round_zero,
    input wire logic                alu_done
);
    import fpc_pkg::*;
    wire take   = ins_valid && ins_ready;
    wire go_alu = take && (ins.op == OP_ARITH || ins.op == OP_CMP || ins.op == OP_TEST);
    wire ld_ctx = take && ins.op == OP_LDCTX;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_store_answer: assert property (take && ins.op == OP_STORE |=> rd_valid)
        else $error("store gave no read answer");
    chk_local_ready: assert property (take && ins.op == OP_MOVE |=> ins_ready)
        else $error("move blocked the next instruction");
    chk_alu_launch: assert property (go_alu |=> alu_req && !ins_ready && alu_op == $past(ins.op))
        else $error("arithmetic request not launched");
    chk_req_pulse: assert property (alu_req |=> !alu_req)
        else $error("arithmetic request longer than one cycle");
    chk_busy_release: assert property (!ins_ready && alu_done |=> ins_ready)
        else $error("core stayed busy after the answer");
    chk_host_operand: assert property (go_alu && ins.s1_kind == SRC_HOST && !ins.dbl
        |=> alu_a.hi == $past(host_data) && alu_a.lo == 32'h0)
        else $error("host word not used as first source");
    chk_round_follow: assert property (ld_ctx && host_data[31:28] == SEL_ALL
        |-> ##2 alu_round_sel == $past(host_data[27:26], 2))
        else $error("round select did not follow context load");
    chk_int_follow: assert property (ld_ctx && host_data[31:28] == SEL_ALL
        |-> ##2 alu_int_round_zero == $past(host_data[25], 2))
        else $error("integer rounding bit did not follow context load");
    chk_round_kept: assert property (ld_ctx && host_data[31:28] == SEL_KEEP_RC && !$past(ld_ctx)
        |-> ##2 $stable(alu_round_sel))
        else $error("partial context load changed rounding");
    chk_trap_cause: assert property ($rose(trap_request)
        |-> $past(alu_done && !ins_ready) || $past(take) || $past(take, 2))
        else $error("trap raised without an instruction end");
    chk_trap_hold: assert property (trap_request && !ld_ctx |=> trap_request)
        else $error("trap dropped without a context load");
endmodule

bind fpc_core fpc_core_checker #(.NREGS(NREGS)) i_fpc_core_checker (
    .clk(clk), .rst_b(rst_b), .ins_valid(ins_valid), .ins(ins), .host_data(host_data),
    .ins_ready(ins_ready), .rd_valid(rd_valid), .trap_request(trap_request), .alu_req(alu_req),
    .alu_op(alu_op), .alu_a(alu_a), .alu_round_sel(alu_round_sel),
    .alu_int_round_zero(alu_int_round_zero), .alu_done(alu_done)
);
`default_nettype wire

// File: fpc_alu_model.sv
// Behavioural arithmetic unit answering the core's requests
`timescale 1ns/10ps
`default_nettype none
module fpc_alu_model (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_b,
    // Request from core
    input  wire logic                alu_req,
    input  wire fpc_pkg::fpc_dword_t alu_a,
    input  wire fpc_pkg::fpc_dword_t alu_b,
    // Answer settings from bench
    input  wire logic [3:0]          lat,
    input  wire logic [7:0]          exc_cfg,
    input  wire fpc_pkg::fpc_cmp_t   cmp_cfg,
    // Answer to core
    output logic                     alu_done,
    output fpc_pkg::fpc_dword_t      alu_res,
    output logic [7:0]               alu_exc,
    output fpc_pkg::fpc_cmp_t        alu_cmp
);
    import fpc_pkg::*;
    logic [3:0] cnt_r;
    fpc_dword_t sum_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r    <= 4'h0;
            alu_done <= 1'b0;
        end else begin
            alu_done <= cnt_r == 4'h1;
            if (alu_req)
                cnt_r <= lat;
            else if (cnt_r != 4'h0)
                cnt_r <= cnt_r - 4'h1;
        end
    end
    // Plain add, so operand routing shows in the result
    always_ff @(posedge clk)
        if (alu_req)
            sum_r <= '{alu_a.hi + alu_b.hi, alu_a.lo + alu_b.lo};
    // Junk outside the answer cycle catches sampling at the wrong time
    assign alu_res = alu_done ? sum_r : ~sum_r;
    assign alu_exc = alu_done ? exc_cfg : ~exc_cfg;
    assign alu_cmp = fpc_cmp_t'(alu_done ? cmp_cfg : ~cmp_cfg);
endmodule
`default_nettype wire

// File: test_fpc_core.sv
// Self-checking testbench of the coprocessor core
`timescale 1ns/10ps
`default_nettype none
module test_fpc_core;
    import fpc_pkg::*;
    logic       clk, rst_b, ins_valid, ins_ready, rd_valid, alu_req, alu_done, alu_iz, trap_request;
    fpc_instr_t ins;
    logic [31:0] host_data, rd_data;
    fpc_dword_t alu_a, alu_b, alu_res;
    logic [7:0] alu_exc, exc_cfg;
    logic [3:0] lat;
    logic [1:0] alu_rs;
    fpc_cmp_t   alu_cmp, cmp_cfg;
    logic [7:0] cc_exp [4] = '{8'h40, 8'h01, 8'h00, 8'h45};
    int         error_cnt, checks_done, i;

    fpc_core i_fpc_core (.clk(clk), .rst_b(rst_b), .ins_valid(ins_valid), .ins(ins),
        .host_data(host_data), .ins_ready(ins_ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .alu_req(alu_req), .alu_op(), .alu_dbl(), .alu_a(alu_a), .alu_b(alu_b),
        .alu_round_sel(alu_rs), .alu_int_round_zero(alu_iz), .alu_done(alu_done),
        .alu_res(alu_res), .alu_exc(alu_exc), .alu_cmp(alu_cmp), .trap_request(trap_request));
    fpc_alu_model i_fpc_alu_model (.clk(clk), .rst_b(rst_b), .alu_req(alu_req), .alu_a(alu_a),
        .alu_b(alu_b), .lat(lat), .exc_cfg(exc_cfg), .cmp_cfg(cmp_cfg), .alu_done(alu_done),
        .alu_res(alu_res), .alu_exc(alu_exc), .alu_cmp(alu_cmp));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Bounded wait; ready only moves at edges, so 1 ns after one is safe
    task automatic wait_ready();
        int n;
        n = 0;
        while (ins_ready !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 100)
            error_cnt++;
    endtask
    task automatic issue(input logic [3:0] op, input logic [1:0] k, input logic [4:0] s2,
                         input logic [4:0] s1, input logic [31:0] hd, input logic d = 1'b0);
        // One idle edge keeps back-to-back calls from retoggling valid
        @(posedge clk);
        #1;
        wait_ready();
        ins = '{op, d, k, s2, s1};
        host_data = hd;
        ins_valid = 1'b1;
        @(posedge clk);
        #1;
        ins_valid = 1'b0;
        host_data = ~hd;
    endtask
    task automatic rd(input logic [3:0] op, input logic [4:0] s2, input logic [31:0] exp);
        issue(op, SRC_REG, s2, 5'h0, 32'h0);
        check({31'h0, rd_valid}, 32'h1);
        check(rd_data, exp);
    endtask
    task automatic alu(input logic [3:0] op, input logic [4:0] s2, input logic [4:0] s1,
                       input logic [1:0] k, input logic [31:0] hd, input logic d, input logic [7:0] e);
        exc_cfg = e;
        issue(op, k, s2, s1, hd, d);
        wait_ready();
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Whole run is a few hundred cycles; this allows forty thousand
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        rst_b = 1'b0;
        ins_valid = 1'b0;
        ins = '0;
        host_data = 32'h0;
        lat = 4'h3;
        exc_cfg = 8'h00;
        cmp_cfg = FPC_CMP_GT;
        error_cnt = 0;
        checks_done = 0;
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        rd(OP_STCTX, 5'h0, 32'h01FD0000);
        check({31'h0, trap_request}, 32'h0);
        $display("test reset done");
        for (i = 0; i < 32; i++)
            issue(OP_MOVE, SRC_HOST, i[4:0], 5'h0, 32'h1000 + i);
        for (i = 0; i < 32; i++)
            rd(OP_STORE, i[4:0], 32'h1000 + i);
        $display("test registers done");
        alu(OP_ARITH, 5'h4, 5'h6, SRC_REG, 32'h0, 1'b0, 8'h00);
        rd(OP_STORE, 5'h4, 32'h200A);
        rd(OP_STORE, 5'h6, 32'h1006);
        lat = 4'h1;
        alu(OP_ARITH, 5'h7, 5'h0, SRC_HOST, 32'h10, 1'b0, 8'h00);
        rd(OP_STORE, 5'h7, 32'h1017);
        lat = 4'h9;
        alu(OP_ARITH, 5'h8, 5'hA, SRC_REG, 32'h0, 1'b1, 8'h00);
        rd(OP_STORE, 5'h8, 32'h2012);
        rd(OP_STORE, 5'h9, 32'h2014);
        $display("test operands done");
        // Fast-mode bit always written as one
        issue(OP_LDCTX, SRC_HOST, 5'h0, 5'h0, 32'h0BFD45A1);
        @(posedge clk);
        #1;
        check({30'h0, alu_rs}, 32'h2);
        check({31'h0, alu_iz}, 32'h1);
        rd(OP_STCTX, 5'h0, 32'h0BFD4521);
        issue(OP_LDCTX, SRC_HOST, 5'h0, 5'h0, 32'hC5FD0000);
        rd(OP_STCTX, 5'h0, 32'h0BFD0000);
        for (i = 0; i < 4; i++) begin
            issue(OP_LDCTX, SRC_HOST, 5'h0, 5'h0, {4'h0, i[1:0], 2'h1, 24'hFD0000});
            @(posedge clk);
            #1;
            check({30'h0, alu_rs}, i);
            check({31'h0, alu_iz}, 32'h0);
        end
        issue(OP_LDCTX, SRC_HOST, 5'h0, 5'h0, 32'h510000FF);
        rd(OP_STCTX, 5'h0, 32'h0DFD0000);
        $display("test context done");
        alu(OP_ARITH, 5'hC, 5'hD, SRC_REG, 32'h0, 1'b0, 8'h04);
        check({31'h0, trap_request}, 32'h0);
        alu(OP_ARITH, 5'hC, 5'hD, SRC_REG, 32'h0, 1'b0, 8'h20);
        alu(OP_ARITH, 5'hC, 5'hD, SRC_REG, 32'h0, 1'b0, 8'h80);
        rd(OP_STCTX, 5'h0, 32'h0DFD0024);
        issue(OP_LDCTX, SRC_HOST, 5'h0, 5'h0, 32'hC0FB0024);
        alu(OP_ARITH, 5'hC, 5'hD, SRC_REG, 32'h0, 1'b0, 8'h04);
        check({31'h0, trap_request}, 32'h1);
        rd(OP_STCTX, 5'h0, 32'h0DFB0026);
        issue(OP_LDCTX, SRC_HOST, 5'h0, 5'h0, 32'hC0FD0000);
        check({31'h0, trap_request}, 32'h0);
        rd(OP_STCTX, 5'h0, 32'h0DFD0000);
        $display("test faults done");
        for (i = 0; i < 4; i++) begin
            cmp_cfg = fpc_cmp_t'(i[1:0]);
            alu(i[0] ? OP_TEST : OP_CMP, 5'h3, 5'h5, SRC_REG, 32'h0, 1'b0, 8'h00);
            rd(OP_STCTX, 5'h0, {16'h0DFD, cc_exp[i], 8'h00});
        end
        cmp_cfg = FPC_CMP_EQ;
        alu(OP_ARITH, 5'h3, 5'h5, SRC_REG, 32'h0, 1'b0, 8'h00);
        rd(OP_STCTX, 5'h0, 32'h0DFD4500);
        $display("test compare done");
        issue(OP_LDCTX, SRC_HOST, 5'h0, 5'h0, 32'hC0BD0000);
        issue(4'h9, SRC_REG, 5'h1, 5'h2, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        check({31'h0, trap_request}, 32'h1);
        rd(OP_STCTX, 5'h0, 32'h0DBD0042);
        $display("test opcode done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
